// file: hsr_pkg.sv
// hsr_pkg: register indices, indicator codes and analog window limits
// for the health status block. assumes measured values arrive already
// scaled to the integer units named beside each limit.
package hsr_pkg;

  // ---------------------------------------------------------------
  // register map (word index on the register port)
  // ---------------------------------------------------------------
  localparam logic [15:0] HSR_REG_FAULT_WORD = 16'h0007; // subsystem_fault_word
  localparam logic [15:0] HSR_REG_BLINK_CODE = 16'h0009; // health_blink_code
  localparam logic [15:0] HSR_RESET_WORD     = 16'h0000;

  // ---------------------------------------------------------------
  // fault word bit positions
  // ---------------------------------------------------------------
  localparam int HSR_BIT_POS_COMM    = 0;
  localparam int HSR_BIT_CHARGE_COMM = 1;
  localparam int HSR_BIT_MOTOR_COMM  = 2;
  localparam int HSR_BIT_OUTSIDE_WIN = 3;

  // ---------------------------------------------------------------
  // indicator codes: red n = n, yellow n = 16*n
  // ---------------------------------------------------------------
  localparam logic [15:0] HSR_CODE_HEALTHY   = 16'h0000;
  localparam logic [15:0] HSR_CODE_ACQUIRING = 16'h0100;
  localparam logic [15:0] HSR_YELLOW_WEIGHT  = 16'h0010;

  // ---------------------------------------------------------------
  // analog limits; volts and amps in tenths, temperature in deg F
  // ---------------------------------------------------------------
  localparam logic [15:0] HSR_VBAT_LO      = 16'h0072; // 11.4 V
  localparam logic [15:0] HSR_VBAT_HI      = 16'h00AF; // 17.5 V
  localparam logic [15:0] HSR_VBAT_WARN    = 16'h0079; // 12.1 V
  localparam logic [15:0] HSR_IMOT_JAM     = 16'h002D; // 4.5 A
  localparam logic [15:0] HSR_IMOT_WARN    = 16'h0023; // 3.5 A
  localparam logic [15:0] HSR_V36_LO       = 16'h014A; // 33.0 V
  localparam logic [15:0] HSR_V36_HI       = 16'h0186; // 39.0 V
  localparam logic [15:0] HSR_V5_LO        = 16'h002D; // 4.5 V
  localparam logic [15:0] HSR_V5_HI        = 16'h0037; // 5.5 V
  localparam logic [15:0] HSR_TEMP_LO      = 16'h0000; // 0 F, signed
  localparam logic [15:0] HSR_TEMP_HI      = 16'h00B0; // 176 F

  // priority-10 levels plus healthy
  typedef enum logic [3:0] {
    HSR_LVL_NONE, HSR_LVL_BAT, HSR_LVL_JAM, HSR_LVL_V36, HSR_LVL_MCOMM, HSR_LVL_CCOMM,
    HSR_LVL_IWARN, HSR_LVL_BWARN, HSR_LVL_TEMP, HSR_LVL_V5, HSR_LVL_PCOMM
  } hsr_level_t;

endpackage : hsr_pkg

// file: hsr_window.sv
// hsr_window: compares one measured value against a low and high limit.
// assumes value and limits share the same scaling and signedness.
`timescale 1ns/1ps
module hsr_window
  import hsr_pkg::*;
(
  // measurement and limits
  input  wire logic [15:0] value,
  input  wire logic [15:0] lo_lim,
  input  wire logic [15:0] hi_lim,
  input  wire logic        is_signed,
  // comparison results
  output logic             below,
  output logic             above
);

  // ---------------------------------------------------------------
  // comparison
  // ---------------------------------------------------------------
  // signed mode lets a temperature below zero count as low
  always_comb begin
    if (is_signed) begin
      below = $signed(value) < $signed(lo_lim);
      above = $signed(value) > $signed(hi_lim);
    end else begin
      below = value < lo_lim;
      above = value > hi_lim;
    end
  end

endmodule : hsr_window

// file: hsr_status.sv
// hsr_status: subsystem fault word and health blink code, read by an
// outside supervisory master at register indices 7 and 9.
// assumes measurements and comm-loss levels come from logic on clk;
// upd pulses once per monitoring update with those inputs valid.
//
// Notes on behaviour
// - status word at address 7; zero when all healthy
// - bit0 positioning comm loss, bit1 charge comm, bit2 motor comm
// - bit3 set while battery, 36 V, 5 V supply or temperature is outside its window
// - bits independent; word is sum of weights, at most 15
// - blink code at address 9 shows only the best-priority condition
// - level 1: red five when battery below 11.4 V or above 17.5 V
// - level 2: jam recovery, red once, current over 4.5 A or motor error
// - level 3: red twice when 36 V supply outside 33.0 to 39.0 V
// - 36 V and motor comm blink codes hidden while aux output off; fault word bits still set
// - level 4: red three times when motor controller comm fails
// - level 5: red four times when charge controller comm fails
// - level 6: yellow once when motor current over 3.5 A
// - level 7: yellow twice when battery below 12.1 V
// - level 8: yellow three times when temperature below 0 F or above 176 F
// - level 9: yellow four times when 5 V supply outside 4.5 to 5.5 V
// - level 10: yellow five times when positioning comm fails
// - code: healthy 0, red n is n, yellow n is 16n, acquiring 256
`timescale 1ns/1ps
module hsr_status
  import hsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // monitoring update strobe
  input  wire logic        upd,
  // measured quantities
  input  wire logic [15:0] vbat,
  input  wire logic [15:0] v36,
  input  wire logic [15:0] v5,
  input  wire logic [15:0] imot,
  input  wire logic [15:0] temp,
  // subsystem conditions
  input  wire logic        pos_comm_lost,
  input  wire logic        charge_comm_lost,
  input  wire logic        motor_comm_lost,
  input  wire logic        motor_err,
  input  wire logic        aux_off,
  input  wire logic        pos_acquiring,
  // register read port
  input  wire logic [15:0] rd_addr,
  output logic [15:0]      rd_data,
  // direct views
  output logic             jam_recovery,
  output logic [15:0]      fault_word,
  output logic [15:0]      blink_code
);

  // ---------------------------------------------------------------
  // window comparators
  // ---------------------------------------------------------------
  logic bat_lo, bat_hi, v36_lo, v36_hi, v5_lo, v5_hi, t_lo, t_hi;
  logic jam_hi, warn_hi, bwarn_lo;

  hsr_window u_bat  (.value(vbat), .lo_lim(HSR_VBAT_LO), .hi_lim(HSR_VBAT_HI),
                     .is_signed(1'b0), .below(bat_lo), .above(bat_hi));
  hsr_window u_v36  (.value(v36), .lo_lim(HSR_V36_LO), .hi_lim(HSR_V36_HI),
                     .is_signed(1'b0), .below(v36_lo), .above(v36_hi));
  hsr_window u_v5   (.value(v5), .lo_lim(HSR_V5_LO), .hi_lim(HSR_V5_HI),
                     .is_signed(1'b0), .below(v5_lo), .above(v5_hi));
  hsr_window u_temp (.value(temp), .lo_lim(HSR_TEMP_LO), .hi_lim(HSR_TEMP_HI),
                     .is_signed(1'b1), .below(t_lo), .above(t_hi));
  hsr_window u_jam  (.value(imot), .lo_lim(HSR_IMOT_WARN), .hi_lim(HSR_IMOT_JAM),
                     .is_signed(1'b0), .below(), .above(jam_hi));
  hsr_window u_warn (.value(imot), .lo_lim(HSR_IMOT_WARN), .hi_lim(HSR_IMOT_WARN),
                     .is_signed(1'b0), .below(), .above(warn_hi));
  hsr_window u_bw   (.value(vbat), .lo_lim(HSR_VBAT_WARN), .hi_lim(HSR_VBAT_HI),
                     .is_signed(1'b0), .below(bwarn_lo), .above());

  // ---------------------------------------------------------------
  // condition decode
  // ---------------------------------------------------------------
  logic c_bat, c_jam, c_v36, c_mcomm, c_ccomm, c_iwarn, c_bwarn, c_temp, c_v5;
  logic any_outside;

  // aux output off hides the 36 V and motor comm conditions from the blink code
  assign c_bat   = bat_lo | bat_hi;
  assign c_jam   = jam_hi | motor_err;
  assign c_v36   = (v36_lo | v36_hi) & ~aux_off;
  assign c_mcomm = motor_comm_lost & ~aux_off;
  assign c_ccomm = charge_comm_lost;
  assign c_iwarn = warn_hi;
  assign c_bwarn = bwarn_lo;
  assign c_temp  = t_lo | t_hi;
  assign c_v5    = v5_lo | v5_hi;
  // analog fault bit covers the battery, 36 V, 5 V and temperature windows, unmasked
  assign any_outside = bat_lo | bat_hi | v36_lo | v36_hi | v5_lo | v5_hi
                     | t_lo | t_hi;

  // ---------------------------------------------------------------
  // priority select
  // ---------------------------------------------------------------
  hsr_level_t lvl;

  // first true term wins; level 1 outranks level 10
  always_comb begin
    if (c_bat) begin
      lvl = HSR_LVL_BAT;
    end else if (c_jam) begin
      lvl = HSR_LVL_JAM;
    end else if (c_v36) begin
      lvl = HSR_LVL_V36;
    end else if (c_mcomm) begin
      lvl = HSR_LVL_MCOMM;
    end else if (c_ccomm) begin
      lvl = HSR_LVL_CCOMM;
    end else if (c_iwarn) begin
      lvl = HSR_LVL_IWARN;
    end else if (c_bwarn) begin
      lvl = HSR_LVL_BWARN;
    end else if (c_temp) begin
      lvl = HSR_LVL_TEMP;
    end else if (c_v5) begin
      lvl = HSR_LVL_V5;
    end else if (pos_comm_lost) begin
      lvl = HSR_LVL_PCOMM;
    end else begin
      lvl = HSR_LVL_NONE;
    end
  end

  // ---------------------------------------------------------------
  // code encode
  // ---------------------------------------------------------------
  logic [15:0] code_d;
  logic [15:0] word_d;

  // red n reads n, yellow n reads 16n
  always_comb begin
    case (lvl)
      HSR_LVL_BAT:   code_d = 16'h0005;
      HSR_LVL_JAM:   code_d = 16'h0001;
      HSR_LVL_V36:   code_d = 16'h0002;
      HSR_LVL_MCOMM: code_d = 16'h0003;
      HSR_LVL_CCOMM: code_d = 16'h0004;
      HSR_LVL_IWARN: code_d = HSR_YELLOW_WEIGHT;
      HSR_LVL_BWARN: code_d = 16'h0020;
      HSR_LVL_TEMP:  code_d = 16'h0030;
      HSR_LVL_V5:    code_d = 16'h0040;
      HSR_LVL_PCOMM: code_d = 16'h0050;
      default:       code_d = pos_acquiring ? HSR_CODE_ACQUIRING : HSR_CODE_HEALTHY;
    endcase
  end

  // independent bits, so the word is the sum of their weights
  always_comb begin
    word_d                      = HSR_RESET_WORD;
    word_d[HSR_BIT_POS_COMM]    = pos_comm_lost;
    word_d[HSR_BIT_CHARGE_COMM] = charge_comm_lost;
    word_d[HSR_BIT_MOTOR_COMM]  = motor_comm_lost;
    word_d[HSR_BIT_OUTSIDE_WIN] = any_outside;
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  logic [15:0] word_q, code_q;
  logic        jam_q;

  // whole snapshot reloads each update, so cleared faults drop out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_q <= HSR_RESET_WORD;
      code_q <= HSR_CODE_HEALTHY;
      jam_q  <= 1'b0;
    end else if (upd) begin
      word_q <= word_d;
      code_q <= code_d;
      jam_q  <= (lvl == HSR_LVL_JAM);
    end
  end

  // read data registered; unmapped indices read zero
  logic [15:0] rd_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q <= HSR_RESET_WORD;
    end else if (rd_addr == HSR_REG_FAULT_WORD) begin
      rd_q <= word_q;
    end else if (rd_addr == HSR_REG_BLINK_CODE) begin
      rd_q <= code_q;
    end else begin
      rd_q <= HSR_RESET_WORD;
    end
  end

  assign rd_data      = rd_q;
  assign fault_word   = word_q;
  assign blink_code   = code_q;
  assign jam_recovery = jam_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_upd_bat;
    upd && c_bat;
  endsequence

  property p_word_max;
    @(posedge clk) disable iff (!rst_n)
      upd |=> fault_word == {12'h000, $past(any_outside), $past(motor_comm_lost),
                             $past(charge_comm_lost), $past(pos_comm_lost)};
  endproperty
  a_word_max: assert property (p_word_max) else $error("fault word not sum of flag weights");

  property p_read7;
    @(posedge clk) disable iff (!rst_n)
      (rd_addr == HSR_REG_FAULT_WORD) ##1 $stable(word_q) |-> rd_data == word_q;
  endproperty
  a_read7: assert property (p_read7) else $error("address 7 read wrong");

  property p_read9;
    @(posedge clk) disable iff (!rst_n)
      (rd_addr == HSR_REG_BLINK_CODE) ##1 $stable(code_q) |-> rd_data == code_q;
  endproperty
  a_read9: assert property (p_read9) else $error("address 9 read wrong");

  property p_bat;
    @(posedge clk) disable iff (!rst_n) s_upd_bat |=> blink_code == 16'h0005;
  endproperty
  a_bat: assert property (p_bat) else $error("battery code not 5");

  property p_jam;
    @(posedge clk) disable iff (!rst_n)
      upd && !c_bat && c_jam |=> jam_recovery && blink_code == 16'h0001;
  endproperty
  a_jam: assert property (p_jam) else $error("jam code wrong");

  property p_aux;
    @(posedge clk) disable iff (!rst_n)
      upd && aux_off |=> blink_code != 16'h0002 && blink_code != 16'h0003;
  endproperty
  a_aux: assert property (p_aux) else $error("masked fault shown");

  property p_pos;
    @(posedge clk) disable iff (!rst_n)
      upd |=> fault_word[HSR_BIT_POS_COMM] == $past(pos_comm_lost);
  endproperty
  a_pos: assert property (p_pos) else $error("bit 0 mismatch");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      upd && word_d == HSR_RESET_WORD |=> fault_word == HSR_RESET_WORD;
  endproperty
  a_clear: assert property (p_clear) else $error("fault word not cleared");

  property p_healthy;
    @(posedge clk) disable iff (!rst_n)
      upd && lvl == HSR_LVL_NONE && !pos_acquiring |=> blink_code == HSR_CODE_HEALTHY;
  endproperty
  a_healthy: assert property (p_healthy) else $error("healthy code wrong");

endmodule : hsr_status

// file: hsr_master_model.sv
// hsr_master_model: supervisory master that polls the status registers.
// assumes the register port answers on the same rising edge that samples the index.
`timescale 1ns/1ps
module hsr_master_model (
  // clock
  input  wire logic        clk,
  // register read port
  output logic [15:0]      rd_addr,
  input  wire logic [15:0] rd_data
);
  // ---------------------------------------------------------------
  // polling
  // ---------------------------------------------------------------
  // start on an unmapped index so stale data is never mistaken for a reply
  initial rd_addr = 16'h00FF;

  // index held across the sampling edge, reply taken a cycle later
  task automatic poll(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
  endtask : poll
endmodule : hsr_master_model

// file: health_status_reporting_bench.sv
// health_status_reporting_bench: self-checking bench for hsr_status.
// assumes hsr_pkg, hsr_window, hsr_status and hsr_master_model compiled first.
`timescale 1ns/1ps
module health_status_reporting_bench
  import hsr_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        upd = 1'b0;
  logic [15:0] vbat = 16'h0082, v36 = 16'h0168, v5 = 16'h0032, imot = 16'h000A, temp = 16'h0046;
  logic        pos_comm_lost = 0, charge_comm_lost = 0, motor_comm_lost = 0;
  logic        motor_err = 0, aux_off = 0, pos_acquiring = 0;
  logic [15:0] rd_addr, rd_data, fault_word, blink_code;
  logic        jam_recovery;
  int          error_cnt = 0;
  int          compares = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  hsr_status i_dut (.clk(clk), .rst_n(rst_n), .upd(upd), .vbat(vbat), .v36(v36), .v5(v5),
    .imot(imot), .temp(temp), .pos_comm_lost(pos_comm_lost), .charge_comm_lost(charge_comm_lost),
    .motor_comm_lost(motor_comm_lost), .motor_err(motor_err), .aux_off(aux_off),
    .pos_acquiring(pos_acquiring), .rd_addr(rd_addr), .rd_data(rd_data),
    .jam_recovery(jam_recovery), .fault_word(fault_word), .blink_code(blink_code));

  hsr_master_model i_master (.clk(clk), .rd_addr(rd_addr), .rd_data(rd_data));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // one update with the given inputs, then direct and polled checks
  // flags: {acquiring, aux_off, motor_err, motor comm, charge comm, pos comm}
  task automatic run(input logic [15:0] b, s36, s5, im, tp, input logic [5:0] fl,
                     input logic [15:0] w, c, input logic j);
    logic [15:0] d;
    @(negedge clk);
    {vbat, v36, v5, imot, temp} = {b, s36, s5, im, tp};
    {pos_acquiring, aux_off, motor_err, motor_comm_lost, charge_comm_lost, pos_comm_lost} = fl;
    upd = 1'b1;
    @(negedge clk);
    upd = 1'b0;
    check(fault_word, w);
    check(blink_code, c);
    check({15'h0000, jam_recovery}, {15'h0000, j});
    i_master.poll(HSR_REG_FAULT_WORD, d);
    check(d, w);
    i_master.poll(HSR_REG_BLINK_CODE, d);
    check(d, c);
  endtask : run

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // every combination of the four status bits, bit 3 via a low battery
  task automatic sc_bits();
    logic [15:0] c;
    for (int i = 0; i < 16; i++) begin
      // motor comm (level 4) outranks charge comm (level 5)
      c = i[3] ? 16'h0005 : (i[2] ? 16'h0003 : (i[1] ? 16'h0004 : (i[0] ? 16'h0050 : 16'h0000)));
      run(i[3] ? 16'h0064 : 16'h0082, 16'h0168, 16'h0032, 16'h000A, 16'h0046,
          {3'b000, i[2:0]}, i[15:0], c, 1'b0);
    end
  endtask : sc_bits

  // conditions stacked from lowest to highest priority; each must win
  task automatic sc_priority();
    run(16'h0082, 16'h0168, 16'h0032, 16'h000A, 16'h0046, 6'b000001, 16'h0001, 16'h0050, 1'b0);
    run(16'h0082, 16'h0168, 16'h002C, 16'h000A, 16'h0046, 6'b000001, 16'h0009, 16'h0040, 1'b0);
    run(16'h0082, 16'h0168, 16'h002C, 16'h000A, 16'hFFFF, 6'b000001, 16'h0009, 16'h0030, 1'b0);
    run(16'h0078, 16'h0168, 16'h002C, 16'h000A, 16'hFFFF, 6'b000001, 16'h0009, 16'h0020, 1'b0);
    run(16'h0078, 16'h0168, 16'h002C, 16'h0024, 16'hFFFF, 6'b000001, 16'h0009, 16'h0010, 1'b0);
    run(16'h0078, 16'h0168, 16'h002C, 16'h0024, 16'hFFFF, 6'b000011, 16'h000B, 16'h0004, 1'b0);
    run(16'h0078, 16'h0168, 16'h002C, 16'h0024, 16'hFFFF, 6'b000111, 16'h000F, 16'h0003, 1'b0);
    run(16'h0078, 16'h0149, 16'h002C, 16'h0024, 16'hFFFF, 6'b000111, 16'h000F, 16'h0002, 1'b0);
    run(16'h0078, 16'h0149, 16'h002C, 16'h002E, 16'hFFFF, 6'b000111, 16'h000F, 16'h0001, 1'b1);
    run(16'h0071, 16'h0149, 16'h002C, 16'h002E, 16'hFFFF, 6'b000111, 16'h000F, 16'h0005, 1'b0);
    run(16'h0082, 16'h0168, 16'h0032, 16'h000A, 16'h0046, 6'b000000, 16'h0000, 16'h0000, 1'b0);
  endtask : sc_priority

  // limits are strict: values exactly on a limit are in window
  task automatic sc_edges();
    run(16'h0072, 16'h0186, 16'h0037, 16'h0023, 16'h00B0, 6'b000000, 16'h0000, 16'h0020, 1'b0);
    run(16'h00AF, 16'h014A, 16'h002D, 16'h002D, 16'h0000, 6'b000000, 16'h0000, 16'h0010, 1'b0);
    run(16'h00B0, 16'h0187, 16'h0038, 16'h0023, 16'h00B1, 6'b000000, 16'h0008, 16'h0005, 1'b0);
    run(16'h0082, 16'h0187, 16'h0038, 16'h0023, 16'h00B1, 6'b000000, 16'h0008, 16'h0002, 1'b0);
    run(16'h0082, 16'h0168, 16'h0038, 16'h0023, 16'h00B1, 6'b000000, 16'h0008, 16'h0030, 1'b0);
  endtask : sc_edges

  // aux output off hides 36 V and motor comm faults from the blink code, not motor errors
  task automatic sc_aux();
    run(16'h0082, 16'h0149, 16'h0032, 16'h0024, 16'h0046, 6'b010100, 16'h000C, 16'h0010, 1'b0);
    run(16'h0082, 16'h0149, 16'h0032, 16'h000A, 16'h0046, 6'b011100, 16'h000C, 16'h0001, 1'b1);
    run(16'h0082, 16'h0168, 16'h0032, 16'h000A, 16'h0046, 6'b100000, 16'h0000, 16'h0100, 1'b0);
    run(16'h0082, 16'h0168, 16'h0032, 16'h0024, 16'h0046, 6'b100000, 16'h0000, 16'h0010, 1'b0);
  endtask : sc_aux

  // inputs ignored without an update; unmapped index reads zero
  task automatic sc_hold();
    logic [15:0] d;
    @(negedge clk);
    vbat = 16'h0064;
    pos_comm_lost = 1'b1;
    repeat (2) @(negedge clk);
    check(fault_word, 16'h0000);
    check(blink_code, 16'h0010);
    i_master.poll(16'h0008, d);
    check(d, 16'h0000);
  endtask : sc_hold

  // mid-run reset clears every stored view, jam recovery included
  task automatic sc_reset();
    run(16'h0082, 16'h0168, 16'h0032, 16'h002E, 16'h0046, 6'b000001, 16'h0001, 16'h0001, 1'b1);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(fault_word, 16'h0000);
    check(blink_code, 16'h0000);
    check({15'h0000, jam_recovery}, 16'h0000);
    check(rd_data, 16'h0000);
  endtask : sc_reset

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(fault_word, 16'h0000);
    check(blink_code, 16'h0000);
    check(rd_data, 16'h0000);
    sc_bits();
    sc_priority();
    sc_edges();
    sc_aux();
    sc_hold();
    sc_reset();
    final_report();
  end

  // bounded run time; running out counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule : health_status_reporting_bench
